// file: shared/occ_pkg.sv
// occ_pkg: register map, field layout and decode tables for the optical
// channel configuration block.
// assumes a byte-wide register port and a 50 MHz core clock.
package occ_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses on the register port)
    localparam logic [7:0] OFS_CFG_A    = 8'h0E;  // range, rate, pulse width
    localparam logic [7:0] OFS_CFG_B    = 8'h0F;  // averaging select
    localparam logic [7:0] OFS_THRESH   = 8'h10;  // presence threshold
    localparam logic [7:0] OFS_E1_AMP   = 8'h11;  // emitter 1 (infrared)
    localparam logic [7:0] OFS_E2_AMP   = 8'h12;  // emitter 2 (red)
    localparam logic [7:0] OFS_RANGE    = 8'h14;  // both emitter ranges
    localparam logic [7:0] OFS_PILOT    = 8'h15;  // pilot amplitude

    ////////////////////////////////////////////////////////////////////////
    // field positions and reset value
    localparam int CFGA_RANGE_LSB = 6;
    localparam int CFGA_RATE_LSB  = 2;
    localparam int CFGA_PW_LSB    = 0;
    localparam int RNG_E1_LSB     = 0;
    localparam int RNG_E2_LSB     = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // sample-rate codes and caps
    localparam logic [3:0] RATE_ONE_TOP = 4'hA;  // last single-pulse code
    localparam logic [3:0] RATE_TWO_100 = 4'hF;  // two pulses, 100 sps
    localparam logic [3:0] RATE_TWO_84  = 4'hE;  // two pulses, 84 sps
    // single-pulse caps per pulse-width code, one emitter / two emitters
    localparam logic [3:0] CAP_ONE [4] = '{4'hA, 4'h9, 4'h8, 4'h8};
    localparam logic [3:0] CAP_TWO [4] = '{4'h9, 4'h7, 4'h7, 4'h6};
    // samples per second for each rate code
    localparam logic [11:0] RATE_SPS [16] = '{
        12'h00A, 12'h014, 12'h032, 12'h054, 12'h064, 12'h0C8,
        12'h190, 12'h320, 12'h3E8, 12'h640, 12'hC80,
        12'h00A, 12'h014, 12'h032, 12'h054, 12'h064};

    ////////////////////////////////////////////////////////////////////////
    // timing: pulse width in microseconds, converted to core clock cycles
    localparam int PW_US [4]      = '{50, 100, 200, 400};
    localparam int CLK_PERIOD_NS  = 20;
    localparam int NS_PER_US      = 1000;

    ////////////////////////////////////////////////////////////////////////
    // converter and averaging constants
    localparam logic [4:0] ADC_RES_BITS = 5'h13;  // 19 bits at every width
    localparam logic [2:0] AVG_LOG_MAX  = 3'h5;   // 32 samples
    localparam logic [7:0] THRESH_FULL  = 8'hFF;

    // presence detector states
    typedef enum logic [0:0] {
        PRX_WATCH = 1'b0,
        PRX_FOUND = 1'b1
    } occ_prx_t;

endpackage

// file: hdl/occ_core.sv
// occ_core: configuration registers and decode for the optical channel,
// with rate clamping, sample averaging and presence detection.
// assumes a serial front end that turns host transfers into one-cycle
// register strobes, and converter samples arriving one per cycle at most.
//
// Behaviour
// R1: range code selects LSB 7.8125 to 62.5 pA
// R2: codes 0-10 single pulse, 10 to 3200
// R3: codes 11-15 two pulses, 10 to 100
// R4: unsupported rate replaced by highest supportable
// R5: readback returns the substituted rate code
// R6: one emitter caps 3200/1600/1000/1000 per width
// R7: two emitters cap lower; two pulses cap 100/84
// R8: width codes give 50/100/200/400 microseconds
// R9: integration equals pulse width, 19-bit resolution
// R10: averaging codes 1..32, codes 6,7 mean 32
// R11: average and decimate each channel separately
// R12: threshold compared to top 8 count bits
// R13: crossing threshold starts optical acquisition
// R14: threshold 0xFF fires only on saturation
// R15: emitter 1 current: amplitude times 0.2/0.4 mA
// R16: emitter 2 current scaled the same way
// R17: range 00 is 50 mA, 01 is 100 mA
// R18: emitter 1 infrared, emitter 2 red
// R19: presence mode uses pilot amplitude, own range
// R20: unused bits read zero, writes ignored
// R21: all fields reset to zero
`timescale 1ns/1ns
module occ_core #(
    parameter int DATA_W   = 19,
    parameter int CHANNELS = 4
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [7:0]        regAddr,
    input  wire logic              regWrEn,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regRdEn,
    output logic      [7:0]        regRdData,
    // acquisition context
    input  wire logic              dualEmitter,
    input  wire logic              presenceMode,
    // infrared converter count
    input  wire logic              irValid,
    input  wire logic [DATA_W-1:0] irCount,
    // raw samples
    input  wire logic              smpValid,
    input  wire logic [1:0]        smpChan,
    input  wire logic [DATA_W-1:0] smpData,
    // decoded settings
    output logic      [3:0]        adcLsbScale,
    output logic      [11:0]       sampleRateSps,
    output logic      [1:0]        pulsesPerSample,
    output logic      [15:0]       pulseCycles,
    output logic      [15:0]       integCycles,
    output logic      [4:0]        adcResBits,
    output logic      [5:0]        avgCount,
    output logic      [9:0]        irDrive,
    output logic      [9:0]        redDrive,
    // presence events
    output logic                   presenceIrq,
    output logic                   acqStart,
    // averaged samples
    output logic                   avgValid,
    output logic      [1:0]        avgChan,
    output logic      [DATA_W-1:0] avgData
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [1:0] rangeQ;        // converter range code
    logic [3:0] rateQ;         // effective (clamped) rate code
    logic [1:0] pwQ;           // pulse width code
    logic [2:0] avgSelQ;       // averaging select
    logic [7:0] threshQ;       // presence threshold
    logic [7:0] e1AmpQ;        // emitter 1 amplitude
    logic [7:0] e2AmpQ;        // emitter 2 amplitude
    logic [3:0] rngQ;          // both emitter range codes
    logic [7:0] pilotQ;        // pilot amplitude
    logic       wrA;           // write strobe to config a

    assign wrA = regWrEn && (regAddr == occ_pkg::OFS_CFG_A);

    // highest supportable rate for a code, width and emitter count
    function automatic logic [3:0] clampRate(
        input logic [3:0] code,
        input logic [1:0] pw,
        input logic       dual);
        logic [3:0] cap;
        if (code <= occ_pkg::RATE_ONE_TOP) begin
            cap = dual ? occ_pkg::CAP_TWO[pw] : occ_pkg::CAP_ONE[pw]; // R6 R7
        end else if (dual && (pw == 2'h3)) begin
            cap = occ_pkg::RATE_TWO_84; // R7
        end else begin
            cap = occ_pkg::RATE_TWO_100; // R7
        end
        return (code > cap) ? cap : code; // R4
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // config a: range and width stored, rate clamped on entry and whenever
    // the emitter count changes, so readback always shows the live rate
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rangeQ <= occ_pkg::RST_BYTE[1:0]; // R21
            pwQ    <= occ_pkg::RST_BYTE[1:0];
            rateQ  <= occ_pkg::RST_BYTE[3:0];
        end else if (wrA) begin
            rangeQ <= regWrData[occ_pkg::CFGA_RANGE_LSB +: 2];
            pwQ    <= regWrData[occ_pkg::CFGA_PW_LSB +: 2];
            rateQ  <= clampRate(regWrData[occ_pkg::CFGA_RATE_LSB +: 4],
                                regWrData[occ_pkg::CFGA_PW_LSB +: 2],
                                dualEmitter); // R4
        end else begin
            // re-check against a changed emitter count
            rateQ  <= clampRate(rateQ, pwQ, dualEmitter); // R4
        end
    end

    // remaining byte registers; unused bits are dropped on write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avgSelQ <= occ_pkg::RST_BYTE[2:0]; // R21
            threshQ <= occ_pkg::RST_BYTE;
            e1AmpQ  <= occ_pkg::RST_BYTE;
            e2AmpQ  <= occ_pkg::RST_BYTE;
            rngQ    <= occ_pkg::RST_BYTE[3:0];
            pilotQ  <= occ_pkg::RST_BYTE;
        end else if (regWrEn) begin
            if (regAddr == occ_pkg::OFS_CFG_B) begin
                avgSelQ <= regWrData[2:0]; // R20
            end else if (regAddr == occ_pkg::OFS_THRESH) begin
                threshQ <= regWrData;
            end else if (regAddr == occ_pkg::OFS_E1_AMP) begin
                e1AmpQ  <= regWrData;
            end else if (regAddr == occ_pkg::OFS_E2_AMP) begin
                e2AmpQ  <= regWrData;
            end else if (regAddr == occ_pkg::OFS_RANGE) begin
                rngQ    <= regWrData[3:0]; // R20
            end else if (regAddr == occ_pkg::OFS_PILOT) begin
                pilotQ  <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback: one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdData <= occ_pkg::RST_BYTE;
        end else if (regRdEn) begin
            if (regAddr == occ_pkg::OFS_CFG_A) begin
                regRdData <= {rangeQ, rateQ, pwQ}; // R5
            end else if (regAddr == occ_pkg::OFS_CFG_B) begin
                regRdData <= {5'h00, avgSelQ}; // R20
            end else if (regAddr == occ_pkg::OFS_THRESH) begin
                regRdData <= threshQ;
            end else if (regAddr == occ_pkg::OFS_E1_AMP) begin
                regRdData <= e1AmpQ;
            end else if (regAddr == occ_pkg::OFS_E2_AMP) begin
                regRdData <= e2AmpQ;
            end else if (regAddr == occ_pkg::OFS_RANGE) begin
                regRdData <= {4'h0, rngQ}; // R20
            end else if (regAddr == occ_pkg::OFS_PILOT) begin
                regRdData <= pilotQ;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter and timing decode, registered for clean outputs
    logic [2:0] avgLog;   // log2 of averaged group size
    assign avgLog = (avgSelQ > occ_pkg::AVG_LOG_MAX) ? occ_pkg::AVG_LOG_MAX
                                                     : avgSelQ; // R10

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            adcLsbScale     <= 4'h1;
            sampleRateSps   <= occ_pkg::RATE_SPS[0];
            pulsesPerSample <= 2'h1;
            pulseCycles     <= 16'h0000;
            integCycles     <= 16'h0000;
            adcResBits      <= occ_pkg::ADC_RES_BITS;
            avgCount        <= 6'h01;
        end else begin
            // lsb weight in steps of 7.8125 pA, doubling per code
            adcLsbScale     <= 4'(4'h1 << rangeQ); // R1
            sampleRateSps   <= occ_pkg::RATE_SPS[rateQ]; // R2 R3
            pulsesPerSample <= (rateQ > occ_pkg::RATE_ONE_TOP) ? 2'h2
                                                               : 2'h1; // R3
            pulseCycles     <= 16'(occ_pkg::PW_US[pwQ] * occ_pkg::NS_PER_US
                                   / occ_pkg::CLK_PERIOD_NS); // R8
            // integration tracks the pulse, resolution is fixed
            integCycles     <= 16'(occ_pkg::PW_US[pwQ] * occ_pkg::NS_PER_US
                                   / occ_pkg::CLK_PERIOD_NS); // R9
            adcResBits      <= occ_pkg::ADC_RES_BITS; // R9
            avgCount        <= 6'(6'h01 << avgLog); // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // emitter drive in 0.2 mA steps; the upper range doubles the step.
    // codes 10 and 11 are not allowed, so they drive nothing rather than
    // guess at a range the output stage does not have.
    function automatic logic [9:0] scaleDrive(
        input logic [7:0] amp,
        input logic [1:0] rng);
        if (rng == 2'h0) begin
            return {2'h0, amp}; // R17
        end else if (rng == 2'h1) begin
            return {1'b0, amp, 1'b0}; // R17
        end else begin
            return 10'h000; // R17
        end
    endfunction

    // presence mode swaps in the pilot amplitude under each own range
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irDrive  <= 10'h000;
            redDrive <= 10'h000;
        end else begin
            irDrive  <= scaleDrive(presenceMode ? pilotQ : e1AmpQ,
                rngQ[occ_pkg::RNG_E1_LSB +: 2]); // R15 R18 R19
            redDrive <= scaleDrive(presenceMode ? pilotQ : e2AmpQ,
                rngQ[occ_pkg::RNG_E2_LSB +: 2]); // R16 R18 R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // presence detect: fires once per presence phase, re-arms when the
    // mode drops, so a finger resting on the sensor is not reported twice
    occ_pkg::occ_prx_t prxQ;     // detector state
    logic              crossing; // count at or above threshold

    assign crossing = (threshQ == occ_pkg::THRESH_FULL)
                    ? (&irCount) // R14
                    : (irCount[DATA_W-1 -: 8] >= threshQ); // R12

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prxQ        <= occ_pkg::PRX_WATCH;
            presenceIrq <= 1'b0;
            acqStart    <= 1'b0;
        end else begin
            presenceIrq <= 1'b0;
            acqStart    <= 1'b0;
            case (prxQ)
                occ_pkg::PRX_WATCH: begin
                    if (presenceMode && irValid && crossing) begin
                        prxQ        <= occ_pkg::PRX_FOUND;
                        presenceIrq <= 1'b1; // R12
                        acqStart    <= 1'b1; // R13
                    end
                end
                default: begin
                    if (!presenceMode) begin
                        prxQ <= occ_pkg::PRX_WATCH;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel averaging: sums grow by five bits so 32 full-scale
    // samples never overflow; a shorter group setting closes a group early
    localparam int SUM_W = DATA_W + 5;
    logic [SUM_W-1:0] accQ [CHANNELS];  // running sums
    logic [4:0]       cntQ [CHANNELS];  // samples held per channel
    logic [SUM_W-1:0] selSum;           // sum including this sample
    logic [4:0]       lastIdx;          // index that closes a group
    logic             groupEnd;         // this sample closes its group

    assign selSum   = accQ[smpChan] + SUM_W'(smpData);
    assign lastIdx  = 5'((6'h01 << avgLog) - 6'h01);
    assign groupEnd = (cntQ[smpChan] >= lastIdx);

    for (genvar g = 0; g < CHANNELS; g++) begin : gAvg
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                accQ[g] <= '0;
                cntQ[g] <= 5'h00;
            end else if (smpValid && (smpChan == 2'(g))) begin
                if (groupEnd) begin
                    accQ[g] <= '0; // R11
                    cntQ[g] <= 5'h00;
                end else begin
                    accQ[g] <= selSum; // R11
                    cntQ[g] <= cntQ[g] + 5'h01;
                end
            end
        end
    end

    // one decimated result per completed group
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avgValid <= 1'b0;
            avgChan  <= 2'h0;
            avgData  <= '0;
        end else begin
            avgValid <= smpValid && groupEnd; // R11
            if (smpValid && groupEnd) begin
                avgChan <= smpChan;
                avgData <= DATA_W'(selSum >> avgLog); // R10 R11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence sWriteA;
        regWrEn && (regAddr == occ_pkg::OFS_CFG_A);
    endsequence
    sequence sReadA;
        regRdEn && (regAddr == occ_pkg::OFS_CFG_A);
    endsequence

    chk_rate_clamp_write: assert property (sWriteA |=> // R4
        rateQ == clampRate($past(regWrData[5:2]), $past(regWrData[1:0]),
                           $past(dualEmitter)))
        else $error("rate code not clamped on write");
    chk_rate_readback: assert property (sReadA |=> // R5
        regRdData[5:2] == $past(rateQ))
        else $error("rate readback differs from live code");
    chk_avg_saturate: assert property ((avgSelQ >= 3'h5) [*2] |-> // R10
        avgCount == 6'h20)
        else $error("averaging above code five not 32");
    chk_presence_fire: assert property ( // R12
        (prxQ == occ_pkg::PRX_WATCH) && presenceMode && irValid && crossing
        |=> presenceIrq && acqStart ##1 !presenceIrq)
        else $error("presence crossing not reported once");
    chk_sat_only: assert property (presenceIrq |-> // R14
        $past(threshQ) != occ_pkg::THRESH_FULL || $past(&irCount))
        else $error("full threshold fired below saturation");
    chk_bad_range: assert property ((rngQ[1] == 1'b1) [*2] |-> // R17
        irDrive == 10'h000)
        else $error("invalid range drove the emitter");
    chk_pilot_drive: assert property ( // R19
        (presenceMode && rngQ[3:2] == 2'h1) [*2] |->
        redDrive == {1'b0, $past(pilotQ), 1'b0})
        else $error("pilot amplitude not used in presence mode");
    chk_avg_cause: assert property (avgValid |-> // R11
        $past(smpValid) && avgChan == $past(smpChan))
        else $error("averaged output without a closing sample");
    chk_unused_zero: assert property ( // R20
        regRdEn && (regAddr == occ_pkg::OFS_RANGE) |=>
        regRdData[7:4] == 4'h0)
        else $error("unused range bits read non-zero");
    chk_reset_clear: assert property ($rose(rst_n) |-> // R21
        rangeQ == 2'h0 && rateQ == 4'h0 && threshQ == 8'h00 &&
        pilotQ == 8'h00)
        else $error("fields not cleared by reset");

endmodule

// file: test/occ_host_model.sv
// occ_host_model: host software stand-in driving the register port.
// assumes the bench calls its tasks; signals move 1 ns after the edge.
`timescale 1ns/1ns
module occ_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [7:0] regAddr,
    output logic            regWrEn,
    output logic      [7:0] regWrData,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData
);
    ////////////////////////////////////////////////////////////
    // idle port from time zero
    initial begin
        regAddr   = 8'h00;
        regWrEn   = 1'h0;
        regWrData = 8'h00;
        regRdEn   = 1'h0;
    end

    // one write strobe; software never sends range codes 10 or 11
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        regAddr   = a;
        regWrData = (a == occ_pkg::OFS_RANGE) ? (d & 8'h55) : d;
        regWrEn   = 1'h1;
        @(posedge core_clk);
        #1;
        regWrEn   = 1'h0;
        // stale byte inverted so a late sample cannot pass unseen
        regWrData = ~regWrData;
    endtask

    // one read strobe; the byte is taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        regAddr = a;
        regRdEn = 1'h1;
        @(posedge core_clk);
        #1;
        regRdEn = 1'h0;
        d       = regRdData;
    endtask
endmodule

// file: test/occ_core_bench.sv
// occ_core_bench: self-checking bench for the optical channel block.
// assumes occ_pkg is compiled first and the host model drives registers.
`timescale 1ns/1ns
module occ_core_bench;
    // clock, reset and context
    logic        core_clk, rst_n, dualEmitter, presenceMode;
    logic        irValid, smpValid;
    logic [18:0] irCount, smpData;
    logic [1:0]  smpChan, pulsesPerSample, avgChan;
    // register port
    logic [7:0]  regAddr, regWrData, regRdData;
    logic        regWrEn, regRdEn;
    // decoded outputs and events
    logic [3:0]  adcLsbScale;
    logic [11:0] sampleRateSps;
    logic [15:0] pulseCycles, integCycles;
    logic [4:0]  adcResBits;
    logic [5:0]  avgCount;
    logic [9:0]  irDrive, redDrive;
    logic        presenceIrq, acqStart, avgValid;
    logic [18:0] avgData;
    // bench state
    int          failures, samplesChecked, n, s1, s2;
    logic [7:0]  rdv;
    logic [3:0]  e4;
    logic [20:0] avgQ[$];
    int          sps[16] = '{10, 20, 50, 84, 100, 200, 400, 800, 1000,
                             1600, 3200, 10, 20, 50, 84, 100};
    logic [3:0]  capOne[4] = '{4'hA, 4'h9, 4'h8, 4'h8};
    logic [3:0]  capTwo[4] = '{4'h9, 4'h7, 4'h7, 4'h6};
    logic [7:0]  ofs[7] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15};

    ////////////////////////////////////////////////////////////
    occ_core DUT (.core_clk, .rst_n, .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData, .dualEmitter, .presenceMode, .irValid,
        .irCount, .smpValid, .smpChan, .smpData, .adcLsbScale,
        .sampleRateSps, .pulsesPerSample, .pulseCycles, .integCycles,
        .adcResBits, .avgCount, .irDrive, .redDrive, .presenceIrq,
        .acqStart, .avgValid, .avgChan, .avgData);
    occ_host_model HOST (.core_clk, .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData);

    // 50 MHz clock
    initial core_clk = 1'h0;
    always #10 core_clk = ~core_clk;

    // collect averaged results in arrival order
    always @(negedge core_clk) begin
        if (avgValid === 1'h1)
            avgQ.push_back({avgChan, avgData});
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // decoded outputs trail a write by two edges
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // one infrared count; events must follow one cycle later
    task automatic irPulse(input logic [18:0] v, input logic e);
        @(posedge core_clk);
        #1;
        irValid = 1'h1;
        irCount = v;
        @(posedge core_clk);
        #1;
        irValid = 1'h0;
        irCount = ~v;
        check("presenceIrq", presenceIrq, e);
        check("acqStart", acqStart, e);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the tests need well under a millisecond
    initial begin
        #400000;
        failures++;
        $display("watchdog expired");
        finish_test();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        {dualEmitter, presenceMode, irValid, smpValid} = 4'h0;
        {irCount, smpData, smpChan} = 40'h0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        settle();
        check("adcLsbScale", adcLsbScale, 1);
        check("sampleRateSps", sampleRateSps, 10);
        check("pulseCycles", pulseCycles, 2500);
        check("avgCount", avgCount, 1);
        foreach (ofs[i]) begin
            HOST.rd(ofs[i], rdv);
            check("reset register", rdv, 0);
        end
        $display("test reset done");
        // every range and pulse width code
        for (int r = 0; r < 4; r++)
            for (int p = 0; p < 4; p++) begin
                HOST.wr(occ_pkg::OFS_CFG_A, 8'(r * 64 + p));
                settle();
                check("adcLsbScale", adcLsbScale, 1 << r);
                check("pulseCycles", pulseCycles, 2500 << p);
                check("integCycles", integCycles, 2500 << p);
                check("adcResBits", adcResBits, 19);
            end
        $display("test range and width done");
        // every rate code at the shortest pulse width, one emitter
        for (int c = 0; c < 16; c++) begin
            HOST.wr(occ_pkg::OFS_CFG_A, 8'(c * 4));
            settle();
            check("sampleRateSps", sampleRateSps, sps[c]);
            check("pulsesPerSample", pulsesPerSample, c > 10 ? 2 : 1);
        end
        $display("test rate decode done");
        // over-fast codes are clamped and read back clamped
        for (int d = 0; d < 2; d++)
            for (int p = 0; p < 4; p++) begin
                dualEmitter = d[0];
                HOST.wr(occ_pkg::OFS_CFG_A, 8'(40 + p));
                HOST.rd(occ_pkg::OFS_CFG_A, rdv);
                e4 = d ? capTwo[p] : capOne[p];
                check("clamp one pulse", rdv, {e4, p[1:0]});
                settle();
                check("clamped rate", sampleRateSps, sps[e4]);
                HOST.wr(occ_pkg::OFS_CFG_A, 8'(60 + p));
                HOST.rd(occ_pkg::OFS_CFG_A, rdv);
                e4 = (d == 1 && p == 3) ? 4'hE : 4'hF;
                check("clamp two pulse", rdv, {2'h0, e4, p[1:0]});
            end
        dualEmitter = 1'h0;
        $display("test rate clamp done");
        // every averaging code, two channels interleaved back to back
        for (int c = 0; c < 8; c++) begin
            n = 1 << (c > 5 ? 5 : c);
            s1 = 0;
            s2 = 0;
            HOST.wr(occ_pkg::OFS_CFG_B, 8'(c));
            settle();
            check("avgCount", avgCount, n);
            for (int i = 0; i < 2 * n; i++) begin
                @(posedge core_clk);
                #1;
                smpValid = 1'h1;
                smpChan  = i[0] ? 2'h2 : 2'h1;
                smpData  = i[0] ? 19'(1000 + i) : 19'(4 * i + 1);
                if (i[0])
                    s2 += 1000 + i;
                else
                    s1 += 4 * i + 1;
            end
            @(posedge core_clk);
            #1;
            smpValid = 1'h0;
            settle();
            check("result count", avgQ.size(), 2);
            if (avgQ.size() == 2) begin
                check("channel 1 mean", avgQ[0], {2'h1, 19'(s1 / n)});
                check("channel 2 mean", avgQ[1], {2'h2, 19'(s2 / n)});
            end
            avgQ.delete();
        end
        $display("test averaging done");
        // threshold on the top count bits, once per presence phase
        HOST.wr(occ_pkg::OFS_THRESH, 8'h01);
        presenceMode = 1'h1;
        irPulse(19'h007FF, 1'h0);
        irPulse(19'h00800, 1'h1);
        irPulse(19'h7FFFF, 1'h0);
        presenceMode = 1'h0;
        HOST.wr(occ_pkg::OFS_THRESH, 8'hFF);
        presenceMode = 1'h1;
        irPulse(19'h7FFFE, 1'h0);
        irPulse(19'h7FFFF, 1'h1);
        $display("test presence done");
        // pilot amplitude in presence mode, then per-emitter amplitudes
        HOST.wr(occ_pkg::OFS_E1_AMP, 8'h7F);
        HOST.wr(occ_pkg::OFS_E2_AMP, 8'hFF);
        HOST.wr(occ_pkg::OFS_PILOT, 8'h05);
        HOST.wr(occ_pkg::OFS_RANGE, 8'h04);
        settle();
        check("pilot infrared", irDrive, 5);
        check("pilot red", redDrive, 10);
        presenceMode = 1'h0;
        settle();
        check("irDrive", irDrive, 127);
        check("redDrive", redDrive, 510);
        HOST.wr(occ_pkg::OFS_RANGE, 8'h01);
        settle();
        check("irDrive", irDrive, 254);
        check("redDrive", redDrive, 255);
        $display("test drive done");
        // unused bits and an unmapped offset
        HOST.wr(occ_pkg::OFS_RANGE, 8'hFF);
        HOST.rd(occ_pkg::OFS_RANGE, rdv);
        check("range unused bits", rdv, 8'h05);
        HOST.wr(occ_pkg::OFS_CFG_B, 8'hFF);
        HOST.rd(occ_pkg::OFS_CFG_B, rdv);
        check("averaging unused bits", rdv, 8'h07);
        HOST.wr(8'h13, 8'hA5);
        HOST.rd(8'h13, rdv);
        check("unmapped offset", rdv, 8'h00);
        // reset in mid-run clears the fields again
        rst_n = 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        HOST.rd(occ_pkg::OFS_E2_AMP, rdv);
        check("amplitude after reset", rdv, 8'h00);
        $display("test access done");
        finish_test();
    end
endmodule
